// *** design/channel_router_defs.svh ***
// Constants for the peripheral-processor barrel channel router.
// Assumes inclusion by bare name from design files; definitions only.
`ifndef CHANNEL_ROUTER_DEFS_SVH
`define CHANNEL_ROUTER_DEFS_SVH
`define RANKS_PER_BARREL   5
`define BARRELS            4
`define PROCS              20
`define PROC_W             5
`define CHANNELS           28
`define CHAN_W             5
`define WORD_W             16
`define LEGACY_W           12
`define CH_NARROW_LO_END   5'h09
`define CH_NARROW_HI_START 5'h10
`define CH_NARROW_HI_END   5'h19
`define CH_XBAR_0          5'h00
`define CH_XBAR_1          5'h01
`define CH_XBAR_2          5'h0a
`define CH_XBAR_3          5'h0b
`define CH_COMMON_0        5'h0d
`define CH_COMMON_1        5'h0f
`define CH_DISK_0          5'h1a
`define CH_DISK_1          5'h1b
`define CH_B0_LO           5'h02
`define CH_B0_HI           5'h04
`define CH_B1_LO           5'h05
`define CH_B1_HI           5'h09
`define CH_B2_LO           5'h10
`define CH_B2_HI           5'h14
`define CH_B3_LO           5'h15
`define CH_B3_HI           5'h19
`define REDUCED_NARROW_PROCS 15
`define REDUCED_NARROW_CH    5'h11
`define REDUCED_DMA_CH       4
`define EXP_DMA_10           8
`define EXP_DMA_15           13
`define EXP_DMA_20           18
`define GROUP_DMA_CH         5
`endif

// *** design/channel_router_pkg.sv ***
// Types shared by the channel router files.
// Assumes channel_router_defs.svh is compiled first.
package channel_router_pkg;
  typedef enum logic [1:0] {
    CFG_NARROW  = 2'b00,
    CFG_REDUCED = 2'b01,
    CFG_DIRECT  = 2'b11
  } config_e;
  typedef enum logic [1:0] {
    EXP_NONE = 2'b00,
    EXP_10   = 2'b01,
    EXP_15   = 2'b11,
    EXP_20   = 2'b10
  } expansion_e;
endpackage : channel_router_pkg

// *** design/pp_barrel_channel_router.sv ***
// Channel fabric between barrel processors, channels and central memory.
// Assumes same-clock requesters on core_clk; channels have no ready input.
`timescale 1ns/10ps
`include "channel_router_defs.svh"
module pp_barrel_channel_router (
  input  wire logic                            core_clk,
  input  wire logic                            rst,
  input  wire channel_router_pkg::config_e     cfg_mode,
  input  wire channel_router_pkg::expansion_e  cfg_expansion,
  input  wire logic [`PROCS-1:0]               req_valid,
  input  wire logic [`PROCS*`CHAN_W-1:0]       req_chan,
  input  wire logic [`PROCS-1:0]               req_release,
  input  wire logic [`PROCS-1:0]               req_legacy,
  input  wire logic [`PROCS*`WORD_W-1:0]       req_wdata,
  input  wire logic [`PROCS-1:0]               req_wvalid,
  input  wire logic [`PROCS-1:0]               irq_req,
  output logic [`PROCS-1:0]                    grant,
  output logic [`PROCS-1:0]                    refused,
  output logic [`PROCS-1:0]                    pending,
  output logic [`CHANNELS-1:0]                 chan_busy,
  output logic [`CHANNELS*`PROC_W-1:0]         chan_owner,
  output logic [`CHANNELS*`WORD_W-1:0]         chan_wdata,
  output logic [`CHANNELS-1:0]                 chan_wvalid,
  output logic [`CHANNELS-1:0]                 chan_to_memory,
  output logic [`CHANNELS-1:0]                 chan_via_local_mem,
  output logic [2:0]                           slot,
  output logic [4:0]                           dma_positions,
  output logic [4:0]                           narrow_procs,
  output logic                                 cp_interrupt
);
  // Barrel of a processor index: five consecutive ranks per barrel.
  function automatic logic [1:0] barrel_of(input logic [`PROC_W-1:0] p);
    barrel_of = 2'(p / `RANKS_PER_BARREL);
  endfunction : barrel_of

  // Channel exists in the narrow numbering (0-11 and 20-31 octal).
  function automatic logic narrow_chan(input logic [`CHAN_W-1:0] c);
    narrow_chan = (c <= `CH_NARROW_LO_END) ||
                  (c >= `CH_NARROW_HI_START && c <= `CH_NARROW_HI_END);
  endfunction : narrow_chan

  // Dedicated direct-access channel owned by the given barrel.
  function automatic logic owns_dma(input logic [1:0] b, input logic [`CHAN_W-1:0] c);
    case (b)
      2'h0:    owns_dma = c >= `CH_B0_LO && c <= `CH_B0_HI;
      2'h1:    owns_dma = c >= `CH_B1_LO && c <= `CH_B1_HI;
      2'h2:    owns_dma = c >= `CH_B2_LO && c <= `CH_B2_HI;
      default: owns_dma = c >= `CH_B3_LO && c <= `CH_B3_HI;
    endcase
  endfunction : owns_dma

  // Channel is a special one open to every barrel in direct mode.
  function automatic logic special_chan(input logic [`CHAN_W-1:0] c);
    special_chan = c == `CH_XBAR_0 || c == `CH_XBAR_1 ||
                   c == `CH_XBAR_2 || c == `CH_XBAR_3 ||
                   c == `CH_COMMON_0 || c == `CH_COMMON_1;
  endfunction : special_chan

  // 12-bit legacy words keep their low 12 bits and are zero-extended to 16 bits.
  function automatic logic [`WORD_W-1:0] to_legacy(input logic [`WORD_W-1:0] w);
    to_legacy = {{(`WORD_W-`LEGACY_W){1'b0}}, w[`LEGACY_W-1:0]};
  endfunction : to_legacy

  logic [`CHANNELS-1:0]             busy_r;
  logic [`CHANNELS*`PROC_W-1:0]     owner_r;
  logic [`CHANNELS*`WORD_W-1:0]     wdata_r;
  logic [`CHANNELS-1:0]             wvalid_r;
  logic [`CHANNELS-1:0]             to_mem_r;
  logic [`CHANNELS-1:0]             via_lm_r;
  logic [`PROCS-1:0]                holding_r;
  logic [`PROCS-1:0]                grant_r;
  logic [`PROCS-1:0]                refused_r;
  logic [`PROCS-1:0]                pending_r;
  logic                             irq_r;
  logic [`PROCS-1:0]                legal;
  logic [`PROCS-1:0]                winner;
  logic [`PROCS-1:0]                drop;
  logic [`PROCS-1:0]                proc_exists;
  logic                             direct_barrel [`BARRELS];
  logic [`PROC_W-1:0]               owner_idx [`CHANNELS];

  slot_counter u_slot (
    .core_clk (core_clk),
    .rst      (rst),
    .slot     (slot)
  );

  // Barrels 0-2 are narrow in reduced mode, barrel 3 is direct.
  assign proc_exists = {`PROCS{1'b1}};
  assign narrow_procs = (cfg_mode == channel_router_pkg::CFG_NARROW)  ? 5'(`PROCS) :
                        (cfg_mode == channel_router_pkg::CFG_REDUCED) ?
                        5'(`REDUCED_NARROW_PROCS) : 5'h00;
  always_comb begin
    for (int b = 0; b < `BARRELS; b++) begin
      direct_barrel[b] = (cfg_mode == channel_router_pkg::CFG_DIRECT) ||
                         (cfg_mode == channel_router_pkg::CFG_REDUCED && b == `BARRELS-1);
    end
  end

  // Memory channel positions for the installed direct barrels plus expansion.
  logic [4:0] base_dma;
  logic [4:0] exp_dma;
  assign base_dma = (cfg_mode == channel_router_pkg::CFG_DIRECT)  ? 5'(`GROUP_DMA_CH*`BARRELS) :
                    (cfg_mode == channel_router_pkg::CFG_REDUCED) ? 5'(`REDUCED_DMA_CH) :
                    5'h00;
  assign exp_dma  = (cfg_expansion == channel_router_pkg::EXP_10) ? 5'(`EXP_DMA_10) :
                    (cfg_expansion == channel_router_pkg::EXP_15) ? 5'(`EXP_DMA_15) :
                    (cfg_expansion == channel_router_pkg::EXP_20) ? 5'(`EXP_DMA_20) :
                    5'h00;
  assign dma_positions = 5'(base_dma + exp_dma);

  // Legality of each request against the configuration.
  always_comb begin
    for (int p = 0; p < `PROCS; p++) begin
      logic [`CHAN_W-1:0] c;
      logic [1:0]         b;
      c = req_chan[p*`CHAN_W +: `CHAN_W];
      b = barrel_of(`PROC_W'(p));
      if (!proc_exists[p] || c == `CH_DISK_0 || c == `CH_DISK_1 ||
          c >= 5'(`CHANNELS)) begin
        legal[p] = 1'b0;
      end else if (direct_barrel[b]) begin
        legal[p] = owns_dma(b, c) || special_chan(c);
      end else if (cfg_mode == channel_router_pkg::CFG_REDUCED) begin
        legal[p] = c < `REDUCED_NARROW_CH;
      end else begin
        legal[p] = narrow_chan(c);
      end
    end
  end

  // Lowest-numbered legal requester wins a free channel; the rest wait.
  always_comb begin
    logic [`CHANNELS-1:0] taken;
    taken  = busy_r;
    winner = '0;
    for (int p = 0; p < `PROCS; p++) begin
      logic [`CHAN_W-1:0] c;
      c = req_chan[p*`CHAN_W +: `CHAN_W];
      if (req_valid[p] && legal[p] && !holding_r[p] && c < 5'(`CHANNELS) &&
          !taken[c]) begin
        winner[p] = 1'b1;
        taken[c]  = 1'b1;
      end
    end
  end

  assign drop = req_release & holding_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      busy_r    <= '0;
      owner_r   <= '0;
      holding_r <= '0;
      grant_r   <= '0;
      refused_r <= '0;
      pending_r <= '0;
    end else begin
      grant_r   <= winner;
      refused_r <= req_valid & ~legal & ~holding_r;
      pending_r <= req_valid & legal & ~winner & ~holding_r;
      holding_r <= (holding_r & ~drop) | winner;
      for (int p = 0; p < `PROCS; p++) begin
        if (drop[p]) busy_r[req_chan[p*`CHAN_W +: `CHAN_W]] <= 1'b0;
        if (winner[p]) begin
          busy_r[req_chan[p*`CHAN_W +: `CHAN_W]] <= 1'b1;
          owner_r[req_chan[p*`CHAN_W +: `CHAN_W]*`PROC_W +: `PROC_W] <= `PROC_W'(p);
        end
      end
    end
  end

  // Owner of each channel as an index, so the clocked data path stays free of temporaries.
  always_comb begin
    for (int ch = 0; ch < `CHANNELS; ch++) begin
      owner_idx[ch] = owner_r[ch*`PROC_W +: `PROC_W];
    end
  end

  // Data path: the owner's 16-bit word reaches its channel in one cycle.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wdata_r  <= '0;
      wvalid_r <= '0;
      to_mem_r <= '0;
      via_lm_r <= '0;
    end else begin
      for (int ch = 0; ch < `CHANNELS; ch++) begin
        wvalid_r[ch] <= busy_r[ch] && holding_r[owner_idx[ch]] && req_wvalid[owner_idx[ch]];
        if (busy_r[ch] && req_wvalid[owner_idx[ch]]) begin
          wdata_r[ch*`WORD_W +: `WORD_W] <= req_legacy[owner_idx[ch]] ?
              to_legacy(req_wdata[owner_idx[ch]*`WORD_W +: `WORD_W]) :
              req_wdata[owner_idx[ch]*`WORD_W +: `WORD_W];
        end
        to_mem_r[ch] <= busy_r[ch] && direct_barrel[barrel_of(owner_idx[ch])];
        via_lm_r[ch] <= busy_r[ch] && !direct_barrel[barrel_of(owner_idx[ch])];
      end
    end
  end

  // Any processor can flag the central processor regardless of its state.
  always_ff @(posedge core_clk) begin
    if (rst) irq_r <= 1'b0;
    else     irq_r <= |irq_req;
  end

  assign grant              = grant_r;
  assign refused            = refused_r;
  assign pending            = pending_r;
  assign chan_busy          = busy_r;
  assign chan_owner         = owner_r;
  assign chan_wdata         = wdata_r;
  assign chan_wvalid        = wvalid_r;
  assign chan_to_memory     = to_mem_r;
  assign chan_via_local_mem = via_lm_r;
  assign cp_interrupt       = irq_r;
endmodule : pp_barrel_channel_router

// *** design/slot_counter.sv ***
// Barrel time-slot sequencer: steps through the five ranks of each barrel.
// Assumes one clock core_clk and synchronous active-high reset rst.
`timescale 1ns/10ps
`include "channel_router_defs.svh"
module slot_counter (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  output logic [2:0]                slot
);
  logic [2:0] slot_r;
  logic [2:0] slot_nxt;
  // Each rank gets one cycle of the shared hardware in turn.
  assign slot_nxt = (slot_r == 3'(`RANKS_PER_BARREL - 1)) ? 3'h0 : slot_r + 3'h1;
  always_ff @(posedge core_clk) begin
    if (rst) slot_r <= 3'h0;
    else     slot_r <= slot_nxt;
  end
  assign slot = slot_r;
endmodule : slot_counter

// *** tb/channel_sink.sv ***
// Far-side channel adapter model: takes each word the fabric puts on channel 3.
// Assumes words arrive on core_clk and are never held off.
`timescale 1ns/10ps
`include "channel_router_defs.svh"
module channel_sink (
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  input  wire logic [`CHANNELS-1:0]         chan_wvalid,
  input  wire logic [`CHANNELS*`WORD_W-1:0] chan_wdata,
  output logic [15:0]                       last_word
);
  always_ff @(posedge core_clk) begin
    if (rst) begin
      last_word <= 16'h0000;
    end else if (chan_wvalid[3]) begin
      last_word <= chan_wdata[63:48];
    end
  end
endmodule : channel_sink

// *** tb/pp_barrel_channel_router_tb_top.sv ***
// Bench for the channel router: table of grant and refusal cases, then hand tests.
// Assumes design files, monitor and channel sink are compiled before this file.
`timescale 1ns/10ps
`include "channel_router_defs.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module pp_barrel_channel_router_tb_top;
  typedef struct {channel_router_pkg::config_e m; int p; logic [4:0] c; logic g; logic d;} row_s;
  logic                           core_clk = 1'b0;
  logic                           rst = 1'b1;
  channel_router_pkg::config_e    cfg_mode = channel_router_pkg::CFG_NARROW;
  channel_router_pkg::expansion_e cfg_exp = channel_router_pkg::EXP_NONE;
  logic [`PROCS-1:0]              req_valid = '0, req_release = '0, req_legacy = '0;
  logic [`PROCS-1:0]              req_wvalid = '0, irq_req = '0;
  logic [`PROCS*`CHAN_W-1:0]      req_chan = '0;
  logic [`PROCS*`WORD_W-1:0]      req_wdata = '0;
  logic [`PROCS-1:0]              grant, refused, pending;
  logic [`CHANNELS-1:0]           chan_busy, chan_wvalid, to_mem, via_lm;
  logic [`CHANNELS*`PROC_W-1:0]   chan_owner;
  logic [`CHANNELS*`WORD_W-1:0]   chan_wdata;
  logic [2:0]                     slot;
  logic [4:0]                     dma_pos, n_narrow;
  logic                           cp_interrupt;
  logic [15:0]                    last_word;
  int                             n_mismatch = 0;
  int                             checks = 0;
  // Columns: mode, processor, channel, expected grant, expected direct memory path.
  row_s rows[14] = '{
    '{channel_router_pkg::CFG_NARROW,  0,  5'h00, 1'b1, 1'b0},
    '{channel_router_pkg::CFG_NARROW,  19, 5'h19, 1'b1, 1'b0},
    '{channel_router_pkg::CFG_NARROW,  7,  5'h0c, 1'b0, 1'b0},
    '{channel_router_pkg::CFG_NARROW,  0,  5'h1a, 1'b0, 1'b0},
    '{channel_router_pkg::CFG_NARROW,  3,  5'h1b, 1'b0, 1'b0},
    '{channel_router_pkg::CFG_DIRECT,  0,  5'h02, 1'b1, 1'b1},
    '{channel_router_pkg::CFG_DIRECT,  5,  5'h02, 1'b0, 1'b1},
    '{channel_router_pkg::CFG_DIRECT,  12, 5'h10, 1'b1, 1'b1},
    '{channel_router_pkg::CFG_DIRECT,  17, 5'h10, 1'b0, 1'b1},
    '{channel_router_pkg::CFG_DIRECT,  17, 5'h0b, 1'b1, 1'b1},
    '{channel_router_pkg::CFG_DIRECT,  9,  5'h0d, 1'b1, 1'b1},
    '{channel_router_pkg::CFG_REDUCED, 0,  5'h11, 1'b0, 1'b0},
    '{channel_router_pkg::CFG_REDUCED, 0,  5'h10, 1'b1, 1'b0},
    '{channel_router_pkg::CFG_REDUCED, 15, 5'h15, 1'b1, 1'b1}};
  always #10 core_clk = ~core_clk;
  pp_barrel_channel_router i_dut (.core_clk, .rst, .cfg_mode, .cfg_expansion(cfg_exp), .req_valid,
    .req_chan, .req_release, .req_legacy, .req_wdata, .req_wvalid, .irq_req, .grant, .refused,
    .pending, .chan_busy, .chan_owner, .chan_wdata, .chan_wvalid, .chan_to_memory(to_mem),
    .chan_via_local_mem(via_lm), .slot, .dma_positions(dma_pos), .narrow_procs(n_narrow),
    .cp_interrupt);
  channel_sink i_sink (.core_clk, .rst, .chan_wvalid, .chan_wdata, .last_word);
  task automatic step();
    @(posedge core_clk);
    #1;
  endtask : step
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run
  initial begin
    repeat (16) step();
    `CHK("slot", 3'h0, slot)
    `CHK("busy", '0, chan_busy)
    rst = 1'b0;
    foreach (rows[i]) begin
      cfg_mode = rows[i].m;
      req_chan[rows[i].p*5 +: 5] = rows[i].c;
      req_valid[rows[i].p] = 1'b1;
      step();
      `CHK("grant", rows[i].g, grant[rows[i].p])
      `CHK("refused", !rows[i].g, refused[rows[i].p])
      req_valid[rows[i].p] = 1'b0;
      req_release[rows[i].p] = rows[i].g;
      step();
      // The path flags follow the busy flag by one cycle, so they are read here.
      if (rows[i].g) `CHK("via_local", !rows[i].d, via_lm[rows[i].c])
      if (rows[i].g) `CHK("to_memory", rows[i].d, to_mem[rows[i].c])
      req_release[rows[i].p] = 1'b0;
      step();
      `CHK("freed", 1'b0, chan_busy[rows[i].c])
      $display("row %0d done", i);
    end
    cfg_mode = channel_router_pkg::CFG_NARROW;
    req_chan[9:0] = {5'h03, 5'h03};
    req_valid[1:0] = 2'b11;
    step();
    `CHK("tie_grant", 2'b01, grant[1:0])
    `CHK("tie_pending", 1'b1, pending[1])
    `CHK("owner", 5'h00, chan_owner[19:15])
    req_valid[0] = 1'b0;
    req_wdata[15:0] = 16'habcd;
    req_wvalid[0] = 1'b1;
    req_legacy[0] = 1'b1;
    step();
    `CHK("legacy_word", 16'h0bcd, chan_wdata[63:48])
    req_legacy[0] = 1'b0;
    req_wdata[15:0] = 16'h1234;
    step();
    `CHK("full_word", 16'h1234, chan_wdata[63:48])
    `CHK("sink_first", 16'h0bcd, last_word)
    req_wvalid[0] = 1'b0;
    req_release[0] = 1'b1;
    step();
    req_release[0] = 1'b0;
    `CHK("sink_second", 16'h1234, last_word)
    step();
    `CHK("late_grant", 1'b1, grant[1])
    req_valid[1] = 1'b0;
    req_release[1] = 1'b1;
    step();
    req_release[1] = 1'b0;
    $display("tie and word test done");
    irq_req[7] = 1'b1;
    step();
    `CHK("irq_set", 1'b1, cp_interrupt)
    irq_req[7] = 1'b0;
    step();
    `CHK("irq_clear", 1'b0, cp_interrupt)
    $display("interrupt test done");
    cfg_mode = channel_router_pkg::CFG_REDUCED;
    step();
    `CHK("reduced_dma", 5'h04, dma_pos)
    `CHK("reduced_procs", 5'h0f, n_narrow)
    cfg_mode = channel_router_pkg::CFG_DIRECT;
    step();
    `CHK("direct_dma", 5'h14, dma_pos)
    `CHK("direct_procs", 5'h00, n_narrow)
    cfg_mode = channel_router_pkg::CFG_NARROW;
    step();
    `CHK("base_procs", 5'h14, n_narrow)
    cfg_exp = channel_router_pkg::EXP_10;
    step();
    `CHK("exp10", 5'h08, dma_pos)
    cfg_exp = channel_router_pkg::EXP_15;
    step();
    `CHK("exp15", 5'h0d, dma_pos)
    cfg_exp = channel_router_pkg::EXP_20;
    step();
    `CHK("exp20", 5'h12, dma_pos)
    $display("configuration test done");
    req_chan[4:0] = 5'h05;
    req_valid[0] = 1'b1;
    step();
    req_valid[0] = 1'b0;
    rst = 1'b1;
    step();
    rst = 1'b0;
    `CHK("reset_busy", '0, chan_busy)
    `CHK("reset_slot", 3'h0, slot)
    req_valid[0] = 1'b1;
    step();
    `CHK("regrant", 1'b1, grant[0])
    req_valid[0] = 1'b0;
    req_release[0] = 1'b1;
    step();
    req_release[0] = 1'b0;
    $display("reset test done");
    complete_run();
  end
  initial begin
    #(20 * 1000);
    n_mismatch++;
    complete_run();
  end
endmodule : pp_barrel_channel_router_tb_top

// *** tb/router_monitor.sv ***
// Checker for the channel router: grant, refusal, word path, slot and interrupt timing.
// Assumes binding to the router top with one clock and synchronous active-high reset.
`timescale 1ns/10ps
`include "channel_router_defs.svh"
module router_monitor (
  input wire logic                        core_clk,
  input wire logic                        rst,
  input wire channel_router_pkg::config_e cfg_mode,
  input wire logic [`PROCS-1:0]           req_valid,
  input wire logic [`PROCS*`CHAN_W-1:0]   req_chan,
  input wire logic [`PROCS-1:0]           req_release,
  input wire logic [`PROCS-1:0]           req_legacy,
  input wire logic [`PROCS*`WORD_W-1:0]   req_wdata,
  input wire logic [`PROCS-1:0]           req_wvalid,
  input wire logic [`PROCS-1:0]           irq_req,
  input wire logic [`PROCS-1:0]           grant,
  input wire logic [`PROCS-1:0]           refused,
  input wire logic [`CHANNELS-1:0]        chan_busy,
  input wire logic [`CHANNELS*`PROC_W-1:0] chan_owner,
  input wire logic [`CHANNELS*`WORD_W-1:0] chan_wdata,
  input wire logic [`CHANNELS-1:0]        chan_wvalid,
  input wire logic [2:0]                  slot,
  input wire logic                        cp_interrupt
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Processor 0 holds channel 3.
  sequence owns3;
    chan_busy[3] && chan_owner[19:15] == 5'h00;
  endsequence
  a_slot_step: assert property (slot != 3'h4 |=> slot == $past(slot) + 3'h1)
    else $error("slot did not advance");
  a_slot_wrap: assert property (slot == 3'h4 |=> slot == 3'h0)
    else $error("slot did not wrap");
  a_irq_follow: assert property (
    !$past(rst) |-> cp_interrupt == ($past(irq_req) != '0))
    else $error("interrupt does not follow requests");
  a_one_winner: assert property (
    grant[1] |-> !(grant[0] && $past(req_chan[4:0]) == $past(req_chan[9:5])))
    else $error("two grants for one channel");
  a_grant_busy: assert property (
    grant[0] |-> chan_busy[$past(req_chan[4:0])] &&
                 chan_owner[$past(req_chan[4:0])*5 +: 5] == 5'h00)
    else $error("granted channel not marked busy");
  a_disk_refuse: assert property (
    req_valid[0] && req_chan[4:0] == 5'h1a |=> refused[0])
    else $error("disk channel not refused");
  a_barrel_refuse: assert property (
    cfg_mode == channel_router_pkg::CFG_DIRECT && req_valid[5] && req_chan[29:25] == 5'h02
    |=> refused[5])
    else $error("foreign barrel not refused");
  a_word_path: assert property (
    owns3 ##0 req_wvalid[0] |=> chan_wvalid[3] && chan_wdata[63:48] ==
      ($past(req_legacy[0]) ? {4'h0, $past(req_wdata[11:0])} : $past(req_wdata[15:0])))
    else $error("word not passed to channel");
  a_release_free: assert property (
    owns3 ##0 (req_release[0] && req_chan[4:0] == 5'h03) |=> !chan_busy[3])
    else $error("channel still busy after release");
endmodule : router_monitor
bind pp_barrel_channel_router router_monitor i_mon (.core_clk, .rst, .cfg_mode, .req_valid,
  .req_chan, .req_release, .req_legacy, .req_wdata, .req_wvalid, .irq_req, .grant, .refused,
  .chan_busy, .chan_owner, .chan_wdata, .chan_wvalid, .slot, .cp_interrupt);
